// ---- logic/cftm_pkg.sv ----
package cftm_pkg;

  // Register word offsets (byte addresses, one aligned 32-bit word each)
  localparam logic [9:0] ADDR_GCTRL   = 10'h000; // Global control: mode, sleep
  localparam logic [9:0] ADDR_GSTAT   = 10'h004; // Global status
  localparam logic [9:0] ADDR_CCTRL   = 10'h008; // Channel control
  localparam logic [9:0] ADDR_CSTAT   = 10'h00C; // Channel status
  localparam logic [9:0] ADDR_GTCTL   = 10'h010; // Global test control
  localparam logic [9:0] ADDR_GTCFG   = 10'h014; // Global test config
  localparam logic [9:0] ADDR_LOCK    = 10'h018; // Test protect key
  localparam logic [9:0] ADDR_CRC15   = 10'h01C; // Classic CRC result
  localparam logic [9:0] ADDR_CRC21   = 10'h020; // FD CRC result
  localparam logic [9:0] ADDR_WIN     = 10'h100; // Page window base, 64 words
  localparam logic [9:0] ADDR_WIN_END = 10'h1FC; // Page window last word

  // Field positions
  localparam int MODE_LSB  = 0;  // Mode select [1:0]
  localparam int SLEEP_BIT = 2;  // Sleep request
  localparam int TMS_LSB   = 8;  // Channel test mode select [9:8]
  localparam int TME_BIT   = 10; // Channel test mode enable
  localparam int ICE_BIT   = 11; // Channel interconnect enable
  localparam int RTE_BIT   = 0;  // RAM test enable
  localparam int ICT_BIT   = 1;  // Global interconnect test enable
  localparam int ROM_BIT   = 2;  // Restricted operation mode enable

  // Encodings
  localparam logic [1:0] TMS_STANDARD = 2'h0; // Standard test mode
  localparam logic [1:0] GMODE_OPER   = 2'h0;
  localparam logic [1:0] GMODE_RESET  = 2'h1;
  localparam logic [1:0] GMODE_TEST   = 2'h2;
  localparam logic [1:0] CMODE_COMM   = 2'h0;
  localparam logic [1:0] CMODE_RESET  = 2'h1;
  localparam logic [1:0] CMODE_HALT   = 2'h2;

  // Unlock keys
  localparam logic [15:0] KEY_ONE = 16'h7575;
  localparam logic [15:0] KEY_TWO = 16'h8A8A;

  // Timing
  localparam int CLK_HZ       = 20000000;
  localparam int PCLK_FAST    = 3;  // Stop/reset/test-to-oper bound, pclk
  localparam int PCLK_SLOW    = 10; // Reset to test/oper bound, pclk
  localparam int BITS_TO_RST  = 2;  // To reset, bit times
  localparam int BITS_TO_HALT = 3;  // Reset to halt, bit times
  localparam int BITS_TO_COMM = 4;  // To communication, bit times
  localparam int FRAME_BITS   = 64; // Bus-idle bits within a frame bound
  localparam int IDLE_BITS    = 11; // Recessive bits that mark bus idle

  // Pins of one channel
  typedef struct packed {
    logic tx;
    logic tx_oe;
  } cftm_pin_type;

  // Flags of one frame seen by the protocol core
  typedef struct packed {
    logic err_cond;
    logic ovl_cond;
    logic rx_ok;
  } cftm_evt_type;

  typedef enum logic [1:0] {
    CM_COMM,
    CM_RESET,
    CM_HALT,
    CM_STOP
  } cftm_cmode_type;

endpackage

// ---- logic/cftm_top.sv ----
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/100ps
// What this block does
// - Restricted mode still acknowledges valid received frames except while waiting for bus idle
// - Restricted mode suppresses error and overload frames
// - After suppression wait bus idle, then resync
// - Error counters hold during restricted mode
// - Restricted mode serves transmit requests except while waiting for bus idle
// - Channel status reports new mode after write
// - Global status reports new mode after write
// - Interconnect: tx feeds rx, pin recessive
// - RAM test enable opens whole message RAM
// - RAM paged by 256 bytes, 7-bit select
// - Page window words reach selected page words
// - Unlock needs key one, key two, enable consecutively
// - Global transitions finish within their bounds
// - Channel transitions finish within their bounds
// - Bit times at nominal rate of slowest channel
// - CRC results visible only with test enable
module cftm_top #(
  parameter int RAM_PAGES = 128,  // Pages of 256 bytes
  parameter int BIT_CLKS  = 40    // Clocks per nominal bit, slowest channel
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire logic [9:0]           i_address,
  input  wire logic                 i_read,
  input  wire logic                 i_write,
  input  wire logic [31:0]          i_writedata,
  output logic      [31:0]          o_readdata,
  output logic                      o_waitrequest,
  input  wire logic                 i_can_rx_pin,     // External bus pin
  input  wire logic                 i_core_tx,        // Protocol core transmit bit
  input  wire logic                 i_tx_req,         // Any transmit source request
  input  wire cftm_pkg::cftm_evt_type i_evt,          // Protocol core frame events
  input  wire logic                 i_err_inc,        // Core asks error count step
  input  wire logic [14:0]          i_crc15,          // Last classic CRC
  input  wire logic [20:0]          i_crc21,          // Last FD CRC
  output cftm_pkg::cftm_pin_type    o_can_tx_pin,     // External transmit pin
  output logic                      o_core_rx,        // Receive bit to core
  output logic                      o_ack_drive,      // Drive acknowledge bit
  output logic                      o_errfrm_drive,   // Drive error/overload frame
  output logic                      o_tx_grant,       // Transmit request served
  output logic                      o_cnt_en          // Error counters may move
);

  ////////////////////////////////////////////////////////////////////////////////
  // Bit-time divider and pin synchroniser
  localparam int BW = 16;
  logic [BW-1:0] div_cnt, next_div_cnt; // Clocks within one bit
  logic          bit_tick;              // One-cycle enable per bit
  logic          rx_meta, rx_sync;      // Two-stage pin synchroniser

  always_comb
  begin
    bit_tick     = (div_cnt == BW'(BIT_CLKS - 1));
    next_div_cnt = bit_tick ? '0 : div_cnt + BW'(1);
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      div_cnt <= '0;
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end
    else
    begin
      div_cnt <= next_div_cnt;
      rx_meta <= i_can_rx_pin;
      rx_sync <= rx_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers, unlock sequence, mode transitions
  logic [1:0]  gmode_sel, gmode_cur;       // Global requested / reported
  logic [1:0]  cmode_sel, cmode_cur;       // Channel requested / reported
  logic        gsleep, csleep;             // Sleep requests
  logic [1:0]  tms;                        // Channel test mode select
  logic        tme, ice, ict, rte, rom;    // Test enables
  logic [6:0]  page;                       // RAM page select
  logic [1:0]  unlock;                     // Keys seen in a row
  logic [15:0] gcnt, ccnt;                 // Transition countdowns
  logic [1:0]  next_gmode_sel, next_gmode_cur, next_cmode_sel, next_cmode_cur;
  logic        next_gsleep, next_csleep, next_tme, next_ice, next_ict, next_rte;
  logic        next_rom;
  logic [1:0]  next_tms, next_unlock;
  logic [6:0]  next_page;
  logic [15:0] next_gcnt, next_ccnt;
  logic        wr_acc, rd_acc;             // Bus handshake completes
  logic        gtest;                      // Global test reported

  // Bound in clocks for a transition
  function automatic logic [15:0] bound(input int n_clk, input int n_bit);
    bound = 16'(n_clk + n_bit * BIT_CLKS);
  endfunction

  assign wr_acc = i_write && !o_waitrequest;
  assign rd_acc = i_read && !o_waitrequest;
  assign gtest  = (gmode_cur == cftm_pkg::GMODE_TEST);

  always_comb
  begin
    next_gmode_sel = gmode_sel;
    next_cmode_sel = cmode_sel;
    next_gsleep    = gsleep;
    next_csleep    = csleep;
    next_tms       = tms;
    next_tme       = tme;
    next_ice       = ice;
    next_ict       = ict;
    next_rte       = rte;
    next_rom       = rom;
    next_page      = page;
    next_unlock    = unlock;
    next_gmode_cur = gmode_cur;
    next_cmode_cur = cmode_cur;
    next_gcnt      = gcnt;
    next_ccnt      = ccnt;
    // Any other write breaks the key sequence
    if (wr_acc)
      next_unlock = 2'h0;
    if (wr_acc && i_address == cftm_pkg::ADDR_GCTRL)
    begin
      next_gmode_sel = i_writedata[cftm_pkg::MODE_LSB +: 2];
      next_gsleep    = i_writedata[cftm_pkg::SLEEP_BIT];
      // Bound chosen by target mode for reset, else by current mode
      if (i_writedata[cftm_pkg::MODE_LSB +: 2] == cftm_pkg::GMODE_RESET)
        next_gcnt = bound(0, cftm_pkg::BITS_TO_RST - 1);
      else if (gmode_cur == cftm_pkg::GMODE_TEST)
        next_gcnt = bound(cftm_pkg::PCLK_FAST - 1, 0);
      else
        next_gcnt = bound(cftm_pkg::PCLK_SLOW - 2, 0);
    end
    else if (wr_acc && i_address == cftm_pkg::ADDR_CCTRL)
    begin
      next_cmode_sel = i_writedata[cftm_pkg::MODE_LSB +: 2];
      next_csleep    = i_writedata[cftm_pkg::SLEEP_BIT];
      next_tms       = i_writedata[cftm_pkg::TMS_LSB +: 2];
      next_tme       = i_writedata[cftm_pkg::TME_BIT];
      next_ice       = i_writedata[cftm_pkg::ICE_BIT];
      if (i_writedata[cftm_pkg::MODE_LSB +: 2] == cftm_pkg::CMODE_HALT)
        next_ccnt = bound(0, cftm_pkg::BITS_TO_HALT - 1);
      else
        next_ccnt = bound(0, cftm_pkg::BITS_TO_RST - 1);
    end
    else if (wr_acc && i_address == cftm_pkg::ADDR_GTCTL)
    begin
      next_ict = i_writedata[cftm_pkg::ICT_BIT];
      next_rom = i_writedata[cftm_pkg::ROM_BIT];
      // Enable only straight after both keys
      if (unlock == 2'h2)
        next_rte = i_writedata[cftm_pkg::RTE_BIT];
      else if (!i_writedata[cftm_pkg::RTE_BIT])
        next_rte = 1'b0;
    end
    else if (wr_acc && i_address == cftm_pkg::ADDR_GTCFG)
      next_page = i_writedata[6:0];
    else if (wr_acc && i_address == cftm_pkg::ADDR_LOCK)
    begin
      if (i_writedata[15:0] == cftm_pkg::KEY_ONE)
        next_unlock = 2'h1;
      else if (i_writedata[15:0] == cftm_pkg::KEY_TWO && unlock == 2'h1)
        next_unlock = 2'h2;
    end
    // Leaving global test drops RAM test access
    if (!gtest && gmode_cur == gmode_sel)
      next_rte = 1'b0;
    // Status countdowns
    if (gmode_cur != gmode_sel)
    begin
      if (gcnt == 16'h0000)
        next_gmode_cur = gmode_sel;
      else
        next_gcnt = gcnt - 16'h0001;
    end
    if (cmode_cur != cmode_sel)
    begin
      if (ccnt == 16'h0000)
        next_cmode_cur = cmode_sel;
      else
        next_ccnt = ccnt - 16'h0001;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      gmode_sel <= cftm_pkg::GMODE_RESET;
      gmode_cur <= cftm_pkg::GMODE_RESET;
      cmode_sel <= cftm_pkg::CMODE_RESET;
      cmode_cur <= cftm_pkg::CMODE_RESET;
      gsleep    <= 1'b0;
      csleep    <= 1'b0;
      tms       <= cftm_pkg::TMS_STANDARD;
      tme       <= 1'b0;
      ice       <= 1'b0;
      ict       <= 1'b0;
      rte       <= 1'b0;
      rom       <= 1'b0;
      page      <= 7'h00;
      unlock    <= 2'h0;
      gcnt      <= 16'h0000;
      ccnt      <= 16'h0000;
    end
    else
    begin
      gmode_sel <= next_gmode_sel;
      gmode_cur <= next_gmode_cur;
      cmode_sel <= next_cmode_sel;
      cmode_cur <= next_cmode_cur;
      gsleep    <= next_gsleep;
      csleep    <= next_csleep;
      tms       <= next_tms;
      tme       <= next_tme;
      ice       <= next_ice;
      ict       <= next_ict;
      rte       <= next_rte;
      rom       <= next_rom;
      page      <= next_page;
      unlock    <= next_unlock;
      gcnt      <= next_gcnt;
      ccnt      <= next_ccnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Message RAM, bus answers
  localparam int WORDS = RAM_PAGES * 64;
  logic [31:0] ram [WORDS];              // Message RAM
  logic [12:0] ram_idx;                  // Page and word
  logic        win_hit;                  // Window address
  logic        busy, next_busy;          // Waitrequest state
  logic [31:0] next_rdata;

  assign win_hit = (i_address >= cftm_pkg::ADDR_WIN) && (i_address <= cftm_pkg::ADDR_WIN_END);
  assign ram_idx = {page, i_address[7:2]};

  always_ff @(posedge i_clk)
  begin
    // Window writes land only with RAM test open
    if (wr_acc && win_hit && rte)
      ram[ram_idx] <= i_writedata;
  end

  always_comb
  begin
    next_busy  = 1'b0;
    next_rdata = o_readdata;
    // One wait cycle per access, then answer
    if ((i_read || i_write) && o_waitrequest && !busy)
      next_busy = 1'b1;
    if (i_read && o_waitrequest && !busy)
    begin
      next_rdata = 32'h0000_0000;
      if (i_address == cftm_pkg::ADDR_GCTRL)
        next_rdata = {29'h0, gsleep, gmode_sel};
      else if (i_address == cftm_pkg::ADDR_GSTAT)
        next_rdata = {29'h0, gsleep, gmode_cur};
      else if (i_address == cftm_pkg::ADDR_CCTRL)
        next_rdata = {20'h0, ice, tme, tms, 5'h0, csleep, cmode_sel};
      else if (i_address == cftm_pkg::ADDR_CSTAT)
        next_rdata = {29'h0, csleep, cmode_cur};
      else if (i_address == cftm_pkg::ADDR_GTCTL)
        next_rdata = {29'h0, rom, ict, rte};
      else if (i_address == cftm_pkg::ADDR_GTCFG)
        next_rdata = {25'h0, page};
      else if (i_address == cftm_pkg::ADDR_CRC15)
        next_rdata = tme ? {17'h0, i_crc15} : 32'h0;
      else if (i_address == cftm_pkg::ADDR_CRC21)
        next_rdata = tme ? {11'h0, i_crc21} : 32'h0;
      else if (win_hit && rte)
        next_rdata = ram[ram_idx];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      busy          <= 1'b0;
      o_waitrequest <= 1'b1;
      o_readdata    <= 32'h0000_0000;
    end
    else
    begin
      busy          <= next_busy;
      o_waitrequest <= !next_busy;
      o_readdata    <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Restricted operation, loopback, pin drive
  logic       loop;                    // Internal interconnect active
  logic       wait_idle, next_wait;    // Waiting for bus idle
  logic [3:0] idle_cnt, next_idle;     // Recessive bits seen
  logic       rx_bit;                  // Receive bit before core

  assign loop   = ice && ict;
  assign rx_bit = loop ? i_core_tx : rx_sync;

  always_comb
  begin
    next_wait = wait_idle;
    next_idle = idle_cnt;
    if (rom && (i_evt.err_cond || i_evt.ovl_cond))
    begin
      next_wait = 1'b1;
      next_idle = 4'h0;
    end
    else if (wait_idle && bit_tick)
    begin
      if (!rx_bit)
        next_idle = 4'h0;
      else if (idle_cnt == 4'(cftm_pkg::IDLE_BITS - 1))
        next_wait = 1'b0;
      else
        next_idle = idle_cnt + 4'h1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      wait_idle      <= 1'b0;
      idle_cnt       <= 4'h0;
      o_can_tx_pin   <= '{tx: 1'b1, tx_oe: 1'b0};
      o_core_rx      <= 1'b1;
      o_ack_drive    <= 1'b0;
      o_errfrm_drive <= 1'b0;
      o_tx_grant     <= 1'b0;
      o_cnt_en       <= 1'b0;
    end
    else
    begin
      wait_idle       <= next_wait;
      idle_cnt        <= next_idle;
      o_can_tx_pin.tx <= loop ? 1'b1 : i_core_tx;
      o_can_tx_pin.tx_oe <= 1'b1;
      o_core_rx       <= wait_idle ? 1'b1 : rx_bit;
      o_ack_drive     <= i_evt.rx_ok && !wait_idle;
      o_errfrm_drive  <= (i_evt.err_cond || i_evt.ovl_cond) && !rom;
      o_tx_grant      <= i_tx_req && !wait_idle;
      o_cnt_en        <= i_err_inc && !rom;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  a_restrict_no_err: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rom && i_evt.err_cond |=> !o_errfrm_drive) else $error("error frame in restricted mode");
  a_counter_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rom && i_err_inc |=> !o_cnt_en) else $error("counter moved in restricted mode");
  a_ack_given: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_evt.rx_ok && !wait_idle |=> o_ack_drive) else $error("missing acknowledge");
  a_loop_recessive: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    loop |=> o_can_tx_pin.tx) else $error("pin not recessive in loop");
  a_gmode_bound: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    gmode_cur != gmode_sel |-> ##[1:300] gmode_cur == gmode_sel)
    else $error("global transition too slow");
  a_cmode_bound: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    cmode_cur != cmode_sel |-> ##[1:300] cmode_cur == cmode_sel)
    else $error("channel transition too slow");
  a_unlock_needed: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(rte) |-> $past(unlock) == 2'h2) else $error("RAM test opened without keys");
  a_crc_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rd_acc && !tme && $past(i_address) == cftm_pkg::ADDR_CRC15 |-> o_readdata == 32'h0)
    else $error("CRC visible without test enable");
  a_grant_free: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_tx_req && !wait_idle |=> o_tx_grant) else $error("transmit refused");

endmodule // cftm_top

// ---- test/cftm_bus_node.sv ----
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Far-side bus node: sends frames of pseudo-random bits, otherwise recessive
module cftm_bus_node #(
  parameter int BIT_CLKS = 4                  // Clocks per nominal bit
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_start,    // Begin a frame
  input  wire logic [7:0]             i_bits,     // Frame length in bits
  input  wire cftm_pkg::cftm_pin_type i_dut_pin,  // Device transmit pin
  output logic                        o_bus       // Wired-AND bus level
);
  logic [7:0]  bits_left = 8'h00;    // Bits still to send
  logic [7:0]  tick      = 8'h00;    // Clocks within the current bit
  logic [15:0] lfsr      = 16'hACE1; // Bit pattern source
  logic        node_bit  = 1'b1;     // Own contribution, recessive when idle

  // Bit sequencer, starts with a dominant start bit
  always @(posedge i_clk)
  begin
    if (i_start)
    begin
      bits_left <= i_bits;
      tick <= 8'h00;
      node_bit <= 1'b0;
    end
    else if (bits_left != 8'h00)
    begin
      if (tick == 8'(BIT_CLKS - 1))
      begin
        tick <= 8'h00;
        bits_left <= bits_left - 8'h01;
        lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        node_bit <= (bits_left == 8'h01) ? 1'b1 : (lfsr[0] & lfsr[1]);
      end
      else
        tick <= tick + 8'h01;
    end
  end

  // Bus pulls up to recessive when nobody drives dominant
  assign o_bus = node_bit & (i_dut_pin.tx_oe ? i_dut_pin.tx : 1'b1);
endmodule // cftm_bus_node

// ---- test/cftm_top_test.sv ----
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module cftm_top_test;
  localparam int BC    = 4;   // Clocks per bit, shortened for sim
  localparam int PAGES = 128; // Pages of 256 bytes
  logic                   i_clk, i_rst_n, i_read, i_write, i_core_tx, i_tx_req, i_err_inc;
  logic [9:0]             i_address;
  logic [31:0]            i_writedata, o_readdata;
  logic                   o_waitrequest, bus, o_core_rx, o_ack_drive, o_errfrm_drive;
  logic                   o_tx_grant, o_cnt_en, go, prev;
  logic [7:0]             nbits;
  logic [14:0]            crc15;
  logic [20:0]            crc21;
  logic [31:0]            ram [4];   // Data written to the page window
  logic [63:0]            note;      // Mask and expected read value
  logic [63:0]            exp_q [$]; // Pending read expectations
  cftm_pkg::cftm_evt_type i_evt;
  cftm_pkg::cftm_pin_type o_can_tx_pin;
  int                     fail_count, checked, seed, bad;
  int                     seen [4];  // Ack, error frame, grant, count enable

  cftm_top #(.RAM_PAGES(PAGES), .BIT_CLKS(BC)) dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_can_rx_pin(bus), .i_core_tx(i_core_tx),
    .i_tx_req(i_tx_req), .i_evt(i_evt), .i_err_inc(i_err_inc), .i_crc15(crc15),
    .i_crc21(crc21), .o_can_tx_pin(o_can_tx_pin), .o_core_rx(o_core_rx),
    .o_ack_drive(o_ack_drive), .o_errfrm_drive(o_errfrm_drive),
    .o_tx_grant(o_tx_grant), .o_cnt_en(o_cnt_en));

  cftm_bus_node #(.BIT_CLKS(BC)) node (
    .i_clk(i_clk), .i_start(go), .i_bits(nbits), .i_dut_pin(o_can_tx_pin), .o_bus(bus));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  initial
  begin
    repeat (6000) @(posedge i_clk);
    fail_count++;
    summarize();
  end

  task automatic summarize();
    if (fail_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
    checked++;
    if (seen_v !== exp_v)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon master: hold request until waitrequest is sampled low
  task automatic access(input logic wr_en, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_address <= a;
    i_writedata <= d;
    i_write <= wr_en;
    i_read <= !wr_en;
    do
    begin
      @(posedge i_clk);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) fail_count++;
    i_write <= 1'b0;
    i_read <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    access(1'b1, a, d);
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back({m, e});
    access(1'b0, a, 32'h0000_0000);
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // One-cycle core event with error step and transmit request
  task automatic pulse(input logic [2:0] e, input logic inc, input logic req);
    @(posedge i_clk);
    i_evt <= cftm_pkg::cftm_evt_type'(e);
    i_err_inc <= inc;
    i_tx_req <= req;
    @(posedge i_clk);
    i_evt <= '0;
    i_err_inc <= 1'b0;
    i_tx_req <= 1'b0;
  endtask
  task automatic frame(input logic [7:0] n);
    @(posedge i_clk);
    go <= 1'b1;
    nbits <= n;
    @(posedge i_clk);
    go <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Read monitor and output pulse counters
  always @(posedge i_clk)
  begin
    if (i_read && o_waitrequest === 1'b0)
    begin
      note = exp_q.pop_front();
      check(o_readdata & note[63:32], note[31:0]);
    end
    if (o_ack_drive === 1'b1) seen[0]++;
    if (o_errfrm_drive === 1'b1) seen[1]++;
    if (o_tx_grant === 1'b1) seen[2]++;
    if (o_cnt_en === 1'b1) seen[3]++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    seed = 53003;
    {i_rst_n, i_read, i_write, i_tx_req, i_err_inc, go} = '0;
    {i_address, i_writedata, i_evt, nbits} = '0;
    i_core_tx = 1'b1;
    crc15 = 15'($random(seed));
    crc21 = 21'($random(seed));
    wait_clk(2);
    i_rst_n <= 1'b1;
    check({31'h0, o_can_tx_pin.tx}, 32'h1);
    rd(cftm_pkg::ADDR_GSTAT, {30'h0, cftm_pkg::GMODE_RESET}, 32'h3);
    rd(cftm_pkg::ADDR_CSTAT, {30'h0, cftm_pkg::CMODE_RESET}, 32'h3);
    rd(10'h030, 32'h0, '1);
    rd(cftm_pkg::ADDR_CRC15, 32'h0, '1);
    rd(cftm_pkg::ADDR_WIN, 32'h0, '1);
    wr(cftm_pkg::ADDR_GCTRL, {30'h0, cftm_pkg::GMODE_TEST});
    wait_clk(cftm_pkg::PCLK_SLOW - 2);
    rd(cftm_pkg::ADDR_GSTAT, {30'h0, cftm_pkg::GMODE_TEST}, 32'h3);
    wr(cftm_pkg::ADDR_CCTRL, {30'h0, cftm_pkg::CMODE_HALT});
    wait_clk(cftm_pkg::BITS_TO_HALT * BC - 2);
    rd(cftm_pkg::ADDR_CSTAT, {30'h0, cftm_pkg::CMODE_HALT}, 32'h3);
    wr(cftm_pkg::ADDR_CCTRL, 32'h0000_0C02);
    rd(cftm_pkg::ADDR_CRC15, {17'h0, crc15}, '1);
    rd(cftm_pkg::ADDR_CRC21, {11'h0, crc21}, '1);
    wr(cftm_pkg::ADDR_CCTRL, {30'h0000_0300, cftm_pkg::CMODE_COMM});
    wait_clk(cftm_pkg::BITS_TO_COMM * BC - 2);
    rd(cftm_pkg::ADDR_CSTAT, {30'h0, cftm_pkg::CMODE_COMM}, 32'h3);
    // Broken unlock sequence must keep the window closed
    wr(cftm_pkg::ADDR_LOCK, {16'h0, cftm_pkg::KEY_ONE});
    wr(cftm_pkg::ADDR_GTCFG, 32'h0000_0000);
    wr(cftm_pkg::ADDR_LOCK, {16'h0, cftm_pkg::KEY_TWO});
    wr(cftm_pkg::ADDR_GTCTL, 32'h0000_0001);
    wr(cftm_pkg::ADDR_WIN, 32'h5A5A_5A5A);
    rd(cftm_pkg::ADDR_WIN, 32'h0, '1);
    wr(cftm_pkg::ADDR_LOCK, {16'h0, cftm_pkg::KEY_ONE});
    wr(cftm_pkg::ADDR_LOCK, {16'h0, cftm_pkg::KEY_TWO});
    wr(cftm_pkg::ADDR_GTCTL, 32'h0000_0001);
    // Edge words of first and last page, written then read back
    for (int k = 0; k < 12; k++)
    begin
      wr(cftm_pkg::ADDR_GTCFG, {25'h0, k[1] ? 7'(PAGES - 1) : 7'h00});
      if (k < 4)
      begin
        ram[k] = $random(seed);
        wr(k[0] ? cftm_pkg::ADDR_WIN_END : cftm_pkg::ADDR_WIN, ram[k]);
      end
      else if (k < 8)
        rd(k[0] ? cftm_pkg::ADDR_WIN_END : cftm_pkg::ADDR_WIN, ram[k - 4], '1);
      else
        wr(k[0] ? cftm_pkg::ADDR_WIN_END : cftm_pkg::ADDR_WIN, 32'h0);
    end
    rd(cftm_pkg::ADDR_WIN_END, 32'h0, '1);
    // Interconnect loop: rx follows tx, pin recessive
    wr(cftm_pkg::ADDR_GTCTL, 32'h0000_0002);
    frame(8'h14);
    for (int i = 0; i < 10; i++)
    begin
      @(posedge i_clk);
      prev = i_core_tx;
      i_core_tx <= 1'($random(seed));
      #1;
      if (i > 1) check({31'h0, o_core_rx}, {31'h0, prev});
      check({30'h0, o_can_tx_pin}, 32'h3);
    end
    i_core_tx <= 1'b1;
    wr(cftm_pkg::ADDR_GTCTL, 32'h0000_0000);
    wait_clk(100);
    frame(8'h14);
    wait_clk(3);
    #1;
    check({31'h0, o_core_rx}, 32'h0);
    wait_clk(100);
    seen = '{default: 0};
    pulse(3'h4, 1'b1, 1'b1);
    pulse(3'h1, 1'b0, 1'b0);
    wait_clk(4);
    check(32'(seen[1] != 0), 32'h1);
    check(32'(seen[3] != 0), 32'h1);
    check(32'(seen[0] != 0), 32'h1);
    // Restricted operation with a dominant frame in flight
    wr(cftm_pkg::ADDR_GTCTL, 32'h0000_0004);
    seen = '{default: 0};
    bad = 0;
    frame(8'h1E);
    pulse(3'h4, 1'b1, 1'b0);
    pulse(3'h2, 1'b1, 1'b0);
    pulse(3'h1, 1'b0, 1'b0);
    for (int i = 0; i < 100; i++)
    begin
      @(posedge i_clk);
      if (o_core_rx !== 1'b1) bad++;
    end
    check(32'(bad), 32'h0);
    check(32'(seen[0]), 32'h0);
    wait_clk((cftm_pkg::IDLE_BITS + 8) * BC);
    pulse(3'h1, 1'b1, 1'b1);
    wait_clk(4);
    check(32'(seen[0] != 0), 32'h1);
    check(32'(seen[2] != 0), 32'h1);
    check(32'(seen[1]), 32'h0);
    check(32'(seen[3]), 32'h0);
    wr(cftm_pkg::ADDR_GCTRL, {30'h0, cftm_pkg::GMODE_RESET});
    wait_clk(cftm_pkg::BITS_TO_RST * BC - 2);
    rd(cftm_pkg::ADDR_GSTAT, {30'h0, cftm_pkg::GMODE_RESET}, 32'h3);
    rd(cftm_pkg::ADDR_WIN, 32'h0, '1);
    wait_clk(4);
    check(32'(exp_q.size()), 32'h0);
    summarize();
  end
endmodule // cftm_top_test
